// ---- include/cfg_load_cfg.svh ----
// Purpose: Constants for the configuration clear, load and start-up block.
// Assumes: Included by its bare name from two of the rtl files and from the testbench.
// Notes: Offsets are absent; only timing, step encodings, reset values and CRC settings.
`ifndef CFG_LOAD_CFG_SVH
`define CFG_LOAD_CFG_SVH

// Cycles the memory-clear phase lasts at minimum (25 MHz clock).
`define CFG_CLEAR_CYCLES 8'h10
`define CFG_CLEAR_CNT_W 8

// CRC-16 settings for the frame check.
`define CFG_CRC_INIT 16'hffff
`define CFG_CRC_POLY 16'h1021

// Start-up step encodings, issued one per clock.
`define CFG_STEP_DONE 2'h0
`define CFG_STEP_RELEASE 2'h1
`define CFG_STEP_RESET 2'h2
`define CFG_STEP_WRITE 2'h3

// Reset values of the start-up controls.
`define CFG_RST_FLOP_RESET 1'b1
`define CFG_RST_WRITE_GATE 1'b0
`define CFG_RST_DONE 1'b0
`define CFG_RST_RELEASE 1'b0

`endif

// ---- include/cfg_load_pkg.sv ----
// Purpose: Types shared by the configuration controller files.
// Assumes: Compiled before every rtl file.
// Notes: Constants live in cfg_load_cfg.svh.
package cfg_load_pkg;

  // Controller phases from clearing to user operation.
  typedef enum logic [2:0] {
    st_clear,
    st_wait,
    st_load,
    st_abort,
    st_dll,
    st_start,
    st_user
  } cfg_state_t;

  typedef logic [1:0] step_t;

endpackage

// ---- rtl/config_clear_load_startup.sv ----
// Purpose: Clear, load, check and start-up sequencing of configuration.
// Assumes: Loader logic on clk drives the data and CRC strobes; the
// request pin, status line and lock input are asynchronous pins.
// Notes: The status line is open-drain: status_out is always low and
// status_oe pulls the line down.
// Functional notes
// (RULE1) The device drives the status line low while it clears memory.
// (RULE2) Clearing lasts while the request pin or the status line is low; here only the request pin extends it, a low status line holds st_wait.
// (RULE3) With clearing over and no hold, the status line is released high.
// (RULE4) Mode inputs are captured as the status line rises after clearing.
// (RULE5) The loader sends frames only once it sees the status line high.
// (RULE6) An outside hold of the status line uses an open-drain driver.
// (RULE7) A CRC is computed over loaded data and compared with the embedded one.
// (RULE8) A CRC mismatch pulls the status line low and aborts configuration.
// (RULE9) A reconfiguration request resets the logic and returns to clearing.
// (RULE10) Start-up begins only after a CRC match at the end of loading.
// (RULE11) Start-up raises done, releases outputs, drops flop reset, opens writes.
// (RULE12) The completion flag goes high during start-up and stays low on failure.
// (RULE13) Released outputs drive if assigned; unassigned pins float pulled down.
// (RULE14) Dropping the global flop reset lets every flip-flop change state.
// (RULE15) Raising the global write gate lets RAMs and flip-flops take values.
// (RULE16) When chosen, completion waits until the clock loop reports lock.
// (RULE17) After a CRC abort the status line stays low until a new request.
`timescale 1ns/1ps
`include "cfg_load_cfg.svh"
module config_clear_load_startup import cfg_load_pkg::*; #(
  parameter int MODE_W = 3,
  parameter int IO_COUNT = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Reconfiguration request pin, active low.
  input wire logic reconfig_n,
  // Open-drain status line.
  input wire logic status_in,
  output logic status_out,
  output logic status_oe,
  // Mode selection pins.
  input wire logic [MODE_W-1:0] mode_in,
  output logic [MODE_W-1:0] mode_q,
  // Configuration data stream from the loader.
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic crc_strobe,
  input wire logic [15:0] crc_value,
  input wire logic crc_final,
  output logic crc_error_q,
  // Clock loop lock hold-off.
  input wire logic dll_wait_en,
  input wire logic dll_locked,
  // Start-up controls.
  output logic done_q,
  output logic io_release_q,
  output logic global_flop_reset_q,
  output logic global_write_gate_q,
  // User pin controls.
  input wire logic [IO_COUNT-1:0] io_assigned,
  output logic [IO_COUNT-1:0] io_drive_en,
  output logic [IO_COUNT-1:0] io_pulldown_en
);

  cfg_state_t state_q;
  cfg_state_t state_d;
  logic [`CFG_CLEAR_CNT_W-1:0] clr_cnt_q;
  step_t step_q;
  logic [MODE_W-1:0] mode_s1_q;
  logic [MODE_W-1:0] mode_s2_q;
  logic [MODE_W-1:0] mode_s3_q;
  logic [MODE_W-1:0] mode_lvl_q;
  logic reconfig_lvl;
  logic status_lvl;
  logic lock_lvl;
  logic [15:0] crc_calc;
  logic reconfig_low;
  logic clear_done;
  logic crc_match;
  logic crc_bad;
  logic crc_good_end;
  logic lock_ok;
  logic crc_clear;

  // Pin synchronisers; lock resets low so a stale lock is never trusted.
  pin_sync #(.RST_VAL(1'b1)) u_sync_req (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(reconfig_n),
    .level_out(reconfig_lvl)
  );

  pin_sync #(.RST_VAL(1'b1)) u_sync_status (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(status_in),
    .level_out(status_lvl)
  );

  pin_sync #(.RST_VAL(1'b0)) u_sync_lock (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(dll_locked),
    .level_out(lock_lvl)
  );

  // CRC restarts whenever a check is made or the phase is not st_load.
  frame_crc u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(crc_clear),
    .byte_valid(data_valid && (state_q == st_load)),
    .byte_in(data_byte),
    .crc_out(crc_calc)
  );

  // Decoded conditions used by the sequencer.
  assign reconfig_low = !reconfig_lvl;
  assign clear_done = (clr_cnt_q == `CFG_CLEAR_CYCLES);
  assign crc_match = (crc_value == crc_calc); // RULE7
  assign crc_bad = (state_q == st_load) && crc_strobe && !crc_match;
  assign crc_good_end = (state_q == st_load) && crc_strobe && crc_match &&
                        crc_final;
  assign lock_ok = !dll_wait_en || lock_lvl; // RULE16
  assign crc_clear = (state_q != st_load) || crc_strobe;

  // The line is pulled low while clearing and after an abort.
  assign status_out = 1'b0;
  assign status_oe = (state_q == st_clear) || (state_q == st_abort); // RULE1

  // Pins with a signal drive once released; the rest float pulled down.
  assign io_drive_en = io_release_q ? io_assigned : '0; // RULE13
  assign io_pulldown_en = ~io_drive_en; // RULE13

  // Phase sequencing; a request from any phase goes back to clearing.
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_clear: begin
        if (clear_done && !reconfig_low) begin
          state_d = st_wait; // RULE3
        end
      end
      st_wait: begin
        if (status_lvl) begin
          state_d = st_load; // RULE4
        end
      end
      st_load: begin
        if (crc_bad) begin
          state_d = st_abort; // RULE8
        end else if (crc_good_end) begin
          state_d = st_dll; // RULE10
        end
      end
      st_abort: begin
        state_d = st_abort; // RULE17
      end
      st_dll: begin
        if (lock_ok) begin
          state_d = st_start; // RULE16
        end
      end
      st_start: begin
        if (step_q == `CFG_STEP_WRITE) begin
          state_d = st_user;
        end
      end
      st_user: begin
        state_d = st_user;
      end
      default: begin
        state_d = st_clear;
      end
    endcase
    if (reconfig_low) begin
      state_d = st_clear; // RULE9
    end
  end

  // State, clear timer and start-up step counter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_clear;
      clr_cnt_q <= '0;
      step_q <= `CFG_STEP_DONE;
    end else begin
      state_q <= state_d;
      if (state_q != st_clear || reconfig_low) begin
        clr_cnt_q <= '0; // RULE2
      end else if (!clear_done) begin
        clr_cnt_q <= clr_cnt_q + 1'b1;
      end
      if (state_q == st_start) begin
        step_q <= step_q + 1'b1;
      end else begin
        step_q <= `CFG_STEP_DONE;
      end
    end
  end

  // Mode pins pass three stages and move once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_q <= '0;
      mode_s2_q <= '0;
      mode_s3_q <= '0;
      mode_lvl_q <= '0;
      mode_q <= '0;
    end else begin
      mode_s1_q <= mode_in;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
      mode_lvl_q <= (mode_s2_q == mode_s3_q) ? mode_s3_q : mode_lvl_q;
      if (state_q == st_wait && status_lvl) begin
        mode_q <= mode_lvl_q; // RULE4
      end
    end
  end

  // Abort flag holds until a fresh request clears everything.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_error_q <= 1'b0;
    end else if (crc_bad) begin
      crc_error_q <= 1'b1; // RULE8
    end else if (state_q == st_clear) begin
      crc_error_q <= 1'b0;
    end
  end

  // One start-up operation per clock, in the fixed order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= `CFG_RST_DONE;
      io_release_q <= `CFG_RST_RELEASE;
      global_flop_reset_q <= `CFG_RST_FLOP_RESET;
      global_write_gate_q <= `CFG_RST_WRITE_GATE;
    end else if (state_q == st_clear) begin
      done_q <= `CFG_RST_DONE;
      io_release_q <= `CFG_RST_RELEASE;
      global_flop_reset_q <= `CFG_RST_FLOP_RESET;
      global_write_gate_q <= `CFG_RST_WRITE_GATE;
    end else if (state_q == st_start) begin
      case (step_q)
        `CFG_STEP_DONE: done_q <= 1'b1; // RULE12
        `CFG_STEP_RELEASE: io_release_q <= 1'b1; // RULE11
        `CFG_STEP_RESET: global_flop_reset_q <= 1'b0; // RULE14
        `CFG_STEP_WRITE: global_write_gate_q <= 1'b1; // RULE15
      endcase
    end
  end

  // Checks kept beside the logic they guard.
  property p_clear_drives_low;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_clear) |-> (status_oe && !status_out);
  endproperty
  a_clear_drives_low: assert property (p_clear_drives_low) // RULE1
    else $error("Status line not pulled low while clearing.");

  property p_hold_keeps_clear;
    @(posedge clk) disable iff (!rst_n)
      reconfig_low |=> (state_q == st_clear) && status_oe;
  endproperty
  a_hold_keeps_clear: assert property (p_hold_keeps_clear) // RULE2
    else $error("Request hold did not keep the clearing phase.");

  property p_release_after_clear;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_clear && clear_done && !reconfig_low) |=>
        (!status_oe && state_q == st_wait);
  endproperty
  a_release_after_clear: assert property (p_release_after_clear) // RULE3
    else $error("Status line not released after clearing.");

  property p_mode_capture;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_wait && status_lvl && !reconfig_low) |=>
        (mode_q == $past(mode_lvl_q)) && (state_q == st_load);
  endproperty
  a_mode_capture: assert property (p_mode_capture) // RULE4
    else $error("Mode not captured on status rise.");

  property p_crc_abort;
    @(posedge clk) disable iff (!rst_n)
      (crc_bad && !reconfig_low) |=> (state_q == st_abort) && status_oe &&
        crc_error_q;
  endproperty
  a_crc_abort: assert property (p_crc_abort) // RULE8
    else $error("CRC mismatch did not abort.");

  property p_start_needs_match;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_dll && $past(state_q) == st_load) |->
        $past(crc_strobe && crc_match && crc_final);
  endproperty
  a_start_needs_match: assert property (p_start_needs_match) // RULE10
    else $error("Start-up entered without a CRC match.");

  property p_startup_order;
    @(posedge clk) disable iff (!rst_n)
      ($rose(done_q) && !reconfig_low) |=> io_release_q && global_flop_reset_q
        ##1 !global_flop_reset_q && !global_write_gate_q
        ##1 global_write_gate_q;
  endproperty
  a_startup_order: assert property (p_startup_order) // RULE11
    else $error("Start-up steps out of order.");

  property p_gate_after_reset;
    @(posedge clk) disable iff (!rst_n)
      global_write_gate_q |-> !global_flop_reset_q && done_q;
  endproperty
  a_gate_after_reset: assert property (p_gate_after_reset) // RULE15
    else $error("Write gate open while flop reset held.");

  property p_lock_holdoff;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_dll && dll_wait_en && !lock_lvl) |=> !done_q;
  endproperty
  a_lock_holdoff: assert property (p_lock_holdoff) // RULE16
    else $error("Completion raised before lock.");

  property p_abort_sticks;
    @(posedge clk) disable iff (!rst_n)
      (state_q == st_abort && !reconfig_low) |=> (state_q == st_abort) &&
        status_oe && !done_q;
  endproperty
  a_abort_sticks: assert property (p_abort_sticks) // RULE17
    else $error("Abort left without a reconfiguration request.");

  property p_io_drive;
    @(posedge clk) disable iff (!rst_n)
      (io_drive_en == (io_release_q ? io_assigned : '0)) &&
        ((io_drive_en & io_pulldown_en) == '0);
  endproperty
  a_io_drive: assert property (p_io_drive) // RULE13
    else $error("User pin drive or pull-down wrong.");

endmodule // config_clear_load_startup

// ---- rtl/frame_crc.sv ----
// Purpose: Running CRC-16 over configuration data bytes.
// Assumes: Bytes arrive on the same clock, one per valid cycle.
// Notes: Clear wins over a byte in the same cycle.
`timescale 1ns/1ps
`include "cfg_load_cfg.svh"
module frame_crc import cfg_load_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control and data.
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // Running result.
  output logic [15:0] crc_out
);

  // One byte, MSB first, through the CRC-16 polynomial.
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ `CFG_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Accumulate accepted bytes; restart on clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_out <= `CFG_CRC_INIT;
    end else if (clear) begin
      crc_out <= `CFG_CRC_INIT;
    end else if (byte_valid) begin
      crc_out <= crc_step(crc_out, byte_in);
    end
  end

endmodule // frame_crc

// ---- rtl/pin_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: The pin is asynchronous to clk.
// Notes: The filtered level changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter bit RST_VAL = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level.
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second, to keep metastability contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end

endmodule // pin_sync

// ---- testbench/cfg_loader_model.sv ----
// Purpose: Loader model that feeds bytes and CRC checks to the block.
// Assumes: The bench calls one task per clock of stream traffic.
// Notes: Idle data lines show the inverse of their last value.
`timescale 1ns/1ps
module cfg_loader_model (
  // Clock and resolved status line.
  input wire logic clk,
  input wire logic status_line,
  // Stream towards the device.
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic crc_strobe,
  output logic [15:0] crc_value,
  output logic crc_final,
  // Open-drain hold of the status line.
  output logic hold_oe
);
  // Quiet start with no hold applied.
  initial begin
    data_valid = 1'b0;
    data_byte = 8'h00;
    crc_strobe = 1'b0;
    crc_value = 16'h0000;
    crc_final = 1'b0;
    hold_oe = 1'b0;
  end

  // One clock of stream; stale lines flip so they never look valid.
  task automatic put(input logic v, input logic [7:0] b, input logic s,
                     input logic [15:0] c, input logic f);
    @(posedge clk);
    data_valid <= v;
    data_byte <= v ? b : ~data_byte;
    crc_strobe <= s;
    crc_value <= s ? c : ~crc_value;
    crc_final <= f;
  endtask

  // The hold only pulls low, so it never fights the device.
  task automatic hold(input logic on);
    @(posedge clk);
    hold_oe <= on;
  endtask

  // Frames start once the line is high, with margin for its synchroniser.
  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && status_line !== 1'b1; i++) begin
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
endmodule // cfg_loader_model

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for clear, load, check and start-up.
// Assumes: Default widths; the clear count is already short.
// Notes: Status flags are compared as one vector against expected constants.
`timescale 1ns/1ps
`include "cfg_load_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  logic clk, rst_n, reconfig_n, dll_wait_en, dll_locked;
  logic status_out, status_oe, data_valid, crc_strobe, crc_final;
  logic crc_error_q, done_q, io_release_q, hold_oe;
  logic global_flop_reset_q, global_write_gate_q;
  logic [2:0] mode_in, mode_q, m;
  logic [7:0] data_byte, io_assigned, io_drive_en, io_pulldown_en;
  logic [15:0] crc_value;
  logic [5:0] obs;
  int n_mismatch, num_checks, seed;
  int seq[$] = '{6'h05, 6'h07, 6'h03, 6'h0b};
  wire logic status_line = status_oe ? status_out : ~hold_oe;

  // Flags as {error, pull, gate, flop reset, release, done}.
  assign obs = {crc_error_q, status_oe, global_write_gate_q,
                global_flop_reset_q, io_release_q, done_q};

  config_clear_load_startup i_dut (.clk(clk), .rst_n(rst_n),
    .reconfig_n(reconfig_n), .status_in(status_line),
    .status_out(status_out), .status_oe(status_oe), .mode_in(mode_in),
    .mode_q(mode_q), .data_valid(data_valid), .data_byte(data_byte),
    .crc_strobe(crc_strobe), .crc_value(crc_value), .crc_final(crc_final),
    .crc_error_q(crc_error_q), .dll_wait_en(dll_wait_en),
    .dll_locked(dll_locked), .done_q(done_q), .io_release_q(io_release_q),
    .global_flop_reset_q(global_flop_reset_q),
    .global_write_gate_q(global_write_gate_q), .io_assigned(io_assigned),
    .io_drive_en(io_drive_en), .io_pulldown_en(io_pulldown_en));

  cfg_loader_model i_ldr (.clk(clk), .status_line(status_line),
    .data_valid(data_valid), .data_byte(data_byte),
    .crc_strobe(crc_strobe), .crc_value(crc_value),
    .crc_final(crc_final), .hold_oe(hold_oe));

  // Free-running 25 MHz clock.
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Reference CRC, MSB first with no reflection.
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ `CFG_CRC_POLY : c << 1;
    return c;
  endfunction

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded wait for one flag; a miss is counted by the compare.
  task automatic await(input int idx, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && obs[idx] !== v; i++) @(negedge clk);
    `CHK(obs[idx], v)
  endtask

  // Random bytes, then one check with a good or corrupted CRC.
  task automatic load(input int nb, input bit bad, input bit fin);
    logic [15:0] c;
    logic [7:0] b;
    c = `CFG_CRC_INIT;
    repeat (nb) begin
      b = 8'($random(seed));
      c = crc_upd(c, b);
      i_ldr.put(1'b1, b, 1'b0, 16'h0000, 1'b0);
    end
    i_ldr.put(1'b0, 8'h00, 1'b1, bad ? c ^ 16'h0001 : c, fin);
    i_ldr.put(1'b0, 8'h00, 1'b0, 16'h0000, 1'b0);
  endtask

  // Request pulse long enough to pass the pin synchroniser.
  task automatic request();
    @(posedge clk);
    reconfig_n <= 1'b0;
    repeat (8) @(posedge clk);
    reconfig_n <= 1'b1;
    @(negedge clk);
    `CHK(obs, 6'h14)
  endtask

  // Start-up steps land one per clock in their fixed order.
  task automatic startup();
    await(0, 1'b1, 40);
    foreach (seq[k]) begin
      `CHK(obs, 6'(seq[k]))
      @(negedge clk);
    end
  endtask

  // A hang ends the run as a failure.
  initial begin
    #(4000 * 40);
    n_mismatch++;
    conclude();
  end

  initial begin
    seed = 8933;
    n_mismatch = 0;
    num_checks = 0;
    rst_n = 1'b0;
    reconfig_n = 1'b1;
    dll_wait_en = 1'b0;
    dll_locked = 1'b0;
    mode_in = 3'h0;
    io_assigned = 8'($random(seed));
    m = 3'($random(seed)) | 3'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(obs, 6'h14)
    `CHK(status_out, 1'b0)
    `CHK(io_pulldown_en, 8'hff)
    // Request keeps the device clearing; the status hold then delays mode capture.
    @(posedge clk);
    reconfig_n <= 1'b0;
    i_ldr.hold(1'b1);
    repeat (40) begin
      @(negedge clk);
      `CHK(status_oe, 1'b1)
    end
    @(posedge clk);
    reconfig_n <= 1'b1;
    mode_in <= m;
    await(4, 1'b0, 80);
    repeat (10) begin
      @(negedge clk);
      `CHK(mode_q, 3'h0)
    end
    i_ldr.hold(1'b0);
    repeat (8) @(negedge clk);
    `CHK(mode_q, m)
    @(posedge clk);
    mode_in <= ~m;
    repeat (4) @(negedge clk);
    `CHK(mode_q, m)
    // A corrupted CRC aborts and stays aborted.
    i_ldr.wait_ready();
    load(5, 1'b1, 1'b1);
    repeat (2) @(negedge clk);
    `CHK(obs, 6'h34)
    `CHK(io_drive_en, 8'h00)
    repeat (30) begin
      @(negedge clk);
      `CHK(obs, 6'h34)
    end
    // Recovery, two checks, and a lock hold-off before completion.
    @(posedge clk);
    dll_wait_en <= 1'b1;
    request();
    await(4, 1'b0, 80);
    i_ldr.wait_ready();
    load(4, 1'b0, 1'b0);
    load(3, 1'b0, 1'b1);
    repeat (20) begin
      @(negedge clk);
      `CHK(obs, 6'h04)
    end
    @(posedge clk);
    dll_locked <= 1'b1;
    startup();
    `CHK(io_drive_en, io_assigned)
    `CHK(io_pulldown_en, ~io_assigned)
    `CHK(global_flop_reset_q, 1'b0)
    `CHK(global_write_gate_q, 1'b1)
    // From user mode, a request then an empty final check.
    @(posedge clk);
    dll_wait_en <= 1'b0;
    request();
    await(4, 1'b0, 80);
    i_ldr.wait_ready();
    load(0, 1'b0, 1'b1);
    startup();
    conclude();
  end
endmodule // tb
